// ---- common/flash_cmd_defines.vh ----
// constants for the wrap, power-down and identifier command block
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OPC_SET_WRAP 8'h77
`define OPC_DEEP_PD 8'hb9
`define OPC_RELEASE 8'hab
`define OPC_ID_X1 8'h90
`define OPC_ID_X2 8'h92
`define OPC_ID_X4 8'h94
// ----------------------------------------
// phase lengths
// ----------------------------------------
`define OPC_BITS 5'd8
`define ADDR_BITS 5'd24
`define WRAP_BITS 5'd8
`define DUMMY_CLK_X2 5'd4
`define DUMMY_CLK_X4 5'd6
// ----------------------------------------
// wrap byte fields and reset value
// ----------------------------------------
`define WRAP_DIS_POS 4
`define WRAP_LEN_HI 6
`define WRAP_LEN_LO 5
`define WRAP_CFG_RST 3'h1
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 100
`define PD_ENTRY_NS 3000
`define REL_RECOV_NS 3000
`define ID_RECOV_NS 5000
`define PD_ENTRY_CYC (`PD_ENTRY_NS * `CLK_MHZ / 1000)
`define REL_RECOV_CYC ((`REL_RECOV_NS * `CLK_MHZ + 999) / 1000)
`define ID_RECOV_CYC ((`ID_RECOV_NS * `CLK_MHZ + 999) / 1000)
`endif

// ---- rtl/flash_cmd.v ----
// serial flash command block: burst wrap, deep power-down, identifier reads
`timescale 1ns/100ps
// ----------------------------------------
// Overview of operation
// - 77h, 24 dummy bits, wrap byte stored
// - only wrap byte bits 6..4 are kept
// - disable bit 0 enables 8/16/32/64 wrap
// - stored wrap applies to later quad reads
// - wrap disabled at reset and soft reset; a wrap byte ending in that cycle wins
// - wrapped read address stays inside section
// - B9h needs cs rise right after bit 8
// - power-down entered within entry time
// - in power-down only ABh is recognised
// - device starts out of power-down
// - ABh releases, new frames wait recovery time
// - ABh plus 3 dummies repeats device identifier
// - ABh ignored while write in progress
// - 90h, 24-bit address, identifiers out MSB first
// - address bit 0 selects order, codes alternate
// - 92h two lanes, four dummy clocks
// - 94h four lanes, six dummy clocks
// ----------------------------------------
`include "flash_cmd_defines.vh"
module flash_cmd #(
	parameter [7:0] MANUF_ID = 8'h5a, // arbitrary value
	parameter [7:0] DEVICE_ID = 8'h3c // arbitrary value
) (
	input wire clk_i,
	input wire resetn_i,
	input wire cs_n_i,
	input wire sclk_i,
	input wire [3:0] io_i,
	output reg [3:0] io_o,
	output reg [3:0] io_oe_o,
	input wire write_in_progress_flag_i,
	input wire soft_reset_i,
	input wire rd_load_i,
	input wire rd_next_i,
	input wire [23:0] rd_addr_i,
	output reg [23:0] rd_addr_o,
	output wire wrap_en_o,
	output wire [1:0] wrap_length_field_o,
	output reg powerdown_o,
	output wire busy_o
);
	localparam [5:0] S_OPC = 6'h01;
	localparam [5:0] S_ADR = 6'h02;
	localparam [5:0] S_DMY = 6'h04;
	localparam [5:0] S_WRP = 6'h08;
	localparam [5:0] S_OUT = 6'h10;
	localparam [5:0] S_IGN = 6'h20;
	localparam integer ENT_INT = `PD_ENTRY_CYC;
	localparam integer REL_INT = `REL_RECOV_CYC;
	localparam integer IDR_INT = `ID_RECOV_CYC;
	localparam [15:0] ENT_CYC = ENT_INT[15:0];
	localparam [15:0] REL_CYC = REL_INT[15:0];
	localparam [15:0] IDR_CYC = IDR_INT[15:0];

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg [2:0] sclk_s_r;
	reg [2:0] cs_s_r;
	reg [3:0] io_s1_r;
	reg [3:0] io_s2_r;
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			sclk_s_r <= 3'h0;
			cs_s_r <= 3'h7;
			io_s1_r <= 4'h0;
			io_s2_r <= 4'h0;
		end else begin
			sclk_s_r <= {sclk_s_r[1:0], sclk_i};
			cs_s_r <= {cs_s_r[1:0], cs_n_i};
			io_s1_r <= io_i;
			io_s2_r <= io_s1_r;
		end
	end
	wire cs_act = ~cs_s_r[1];
	wire cs_rise = cs_s_r[1] & ~cs_s_r[2];
	wire sck_rise = sclk_s_r[1] & ~sclk_s_r[2] & cs_act;
	wire sck_fall = ~sclk_s_r[1] & sclk_s_r[2] & cs_act;

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [5:0] st_r;
	reg [7:0] cmd_r;
	reg [2:0] wid_r;
	reg [4:0] cnt_r;
	reg [23:0] sh_r;
	reg exact8_r;
	reg id_order_r;
	reg sel_r;
	reg [7:0] osh_r;
	reg [3:0] ocnt_r;
	reg [2:0] wrap_cfg_r;
	reg ent_r;
	reg rec_r;
	reg frame_ign_r;
	reg [15:0] tmr_r;

	assign busy_o = ent_r | rec_r;
	assign wrap_en_o = ~wrap_cfg_r[0];
	assign wrap_length_field_o = wrap_cfg_r[2:1];

	// bits shifted in on this rising edge, by lane count
	reg [23:0] sh_nxt;
	reg [4:0] cnt_nxt;
	always @* begin
		case (wid_r)
			3'd4: sh_nxt = {sh_r[19:0], io_s2_r};
			3'd2: sh_nxt = {sh_r[21:0], io_s2_r[1:0]};
			default: sh_nxt = {sh_r[22:0], io_s2_r[0]};
		endcase
		cnt_nxt = cnt_r + {2'h0, wid_r};
	end

	// first identifier byte; order bit high puts the device code first
	wire [7:0] first_id = id_order_r ? DEVICE_ID : MANUF_ID;
	wire [7:0] first_id_nxt = sh_nxt[0] ? DEVICE_ID : MANUF_ID;

	// ----------------------------------------
	// instruction decoder
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			st_r <= S_OPC;
			cmd_r <= 8'h00;
			wid_r <= 3'd1;
			cnt_r <= 5'h0;
			sh_r <= 24'h0;
			exact8_r <= 1'b0;
			id_order_r <= 1'b0;
			sel_r <= 1'b0;
			osh_r <= 8'h00;
			ocnt_r <= 4'h0;
			wrap_cfg_r <= `WRAP_CFG_RST;
			io_o <= 4'h0;
			io_oe_o <= 4'h0;
			frame_ign_r <= 1'b0;
		end else begin
			if (soft_reset_i)
				wrap_cfg_r <= `WRAP_CFG_RST;
			if (!cs_act) begin
				// frame over or aborted early
				st_r <= S_OPC;
				wid_r <= 3'd1;
				cnt_r <= 5'h0;
				io_oe_o <= 4'h0;
				frame_ign_r <= busy_o;
				if (cs_rise)
					exact8_r <= 1'b0;
			end else if (sck_rise && !frame_ign_r) begin
				sh_r <= sh_nxt;
				cnt_r <= cnt_nxt;
				exact8_r <= 1'b0;
				case (st_r)
					S_OPC: begin
						if (cnt_nxt == `OPC_BITS) begin
							cmd_r <= sh_nxt[7:0];
							cnt_r <= 5'h0;
							exact8_r <= 1'b1;
							st_r <= S_IGN;
							if (powerdown_o && sh_nxt[7:0] != `OPC_RELEASE) begin
								st_r <= S_IGN;
							end else begin
								case (sh_nxt[7:0])
									`OPC_SET_WRAP: begin
										st_r <= S_ADR;
										wid_r <= 3'd4;
									end
									`OPC_RELEASE: begin
										if (!write_in_progress_flag_i)
											st_r <= S_ADR;
										else
											exact8_r <= 1'b0;
									end
									`OPC_ID_X1: st_r <= S_ADR;
									`OPC_ID_X2: begin
										st_r <= S_ADR;
										wid_r <= 3'd2;
									end
									`OPC_ID_X4: begin
										st_r <= S_ADR;
										wid_r <= 3'd4;
									end
									default: st_r <= S_IGN;
								endcase
							end
						end
					end
					S_ADR: begin
						if (cnt_nxt == `ADDR_BITS) begin
							cnt_r <= 5'h0;
							id_order_r <= sh_nxt[0];
							sel_r <= 1'b0;
							ocnt_r <= 4'h0;
							case (cmd_r)
								`OPC_SET_WRAP: st_r <= S_WRP;
								`OPC_RELEASE: begin
									st_r <= S_OUT;
									osh_r <= DEVICE_ID;
								end
								`OPC_ID_X1: begin
									st_r <= S_OUT;
									osh_r <= first_id_nxt;
								end
								default: st_r <= S_DMY;
							endcase
						end
					end
					S_DMY: begin
						// dummy clocks carry the mode byte, which is ignored
						cnt_r <= cnt_r + 5'h1;
						if (cnt_r + 5'h1 == ((cmd_r == `OPC_ID_X2) ?
							`DUMMY_CLK_X2 : `DUMMY_CLK_X4)) begin
							st_r <= S_OUT;
							osh_r <= first_id;
						end
					end
					S_WRP: begin
						if (cnt_nxt == `WRAP_BITS) begin
							wrap_cfg_r <= {sh_nxt[`WRAP_LEN_HI], sh_nxt[`WRAP_LEN_LO],
								sh_nxt[`WRAP_DIS_POS]};
							st_r <= S_IGN;
						end
					end
					S_OUT: st_r <= S_OUT;
					S_IGN: st_r <= S_IGN;
					default: st_r <= S_IGN;
				endcase
			end else if (sck_fall && st_r == S_OUT) begin
				// shift identifiers out MSB first on falling sclk
				case (wid_r)
					3'd4: begin
						io_o <= osh_r[7:4];
						io_oe_o <= 4'hf;
						osh_r <= {osh_r[3:0], 4'h0};
					end
					3'd2: begin
						io_o <= {2'h0, osh_r[7:6]};
						io_oe_o <= 4'h3;
						osh_r <= {osh_r[5:0], 2'h0};
					end
					default: begin
						io_o <= {2'h0, osh_r[7], 1'b0};
						io_oe_o <= 4'h2;
						osh_r <= {osh_r[6:0], 1'b0};
					end
				endcase
				ocnt_r <= ocnt_r + {1'b0, wid_r};
				if (ocnt_r + {1'b0, wid_r} == 4'h8) begin
					ocnt_r <= 4'h0;
					sel_r <= ~sel_r;
					if (cmd_r == `OPC_RELEASE)
						osh_r <= DEVICE_ID;
					else
						osh_r <= (sel_r ^ id_order_r) ? MANUF_ID : DEVICE_ID;
				end
			end
		end
	end

	// ----------------------------------------
	// power-down entry and release timing
	// ----------------------------------------
	wire dp_go = cs_rise && exact8_r && cmd_r == `OPC_DEEP_PD && !powerdown_o;
	wire rel_go = cs_rise && powerdown_o && cmd_r == `OPC_RELEASE &&
		(exact8_r || st_r == S_OUT);
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			powerdown_o <= 1'b0;
			ent_r <= 1'b0;
			rec_r <= 1'b0;
			tmr_r <= 16'h0;
		end else if (dp_go && !busy_o) begin
			ent_r <= 1'b1;
			tmr_r <= ENT_CYC;
		end else if (rel_go && !busy_o) begin
			powerdown_o <= 1'b0;
			rec_r <= 1'b1;
			tmr_r <= exact8_r ? REL_CYC : IDR_CYC;
		end else if (busy_o) begin
			tmr_r <= tmr_r - 16'h1;
			if (tmr_r <= 16'h1) begin
				ent_r <= 1'b0;
				rec_r <= 1'b0;
				if (ent_r)
					powerdown_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// quad read address stepping with wrap
	// ----------------------------------------
	wire [7:0] wrap_mask = (8'h08 << wrap_cfg_r[2:1]) - 8'h01;
	wire [7:0] lo_inc = rd_addr_o[7:0] + 8'h01;
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			rd_addr_o <= 24'h0;
		end else if (rd_load_i) begin
			rd_addr_o <= rd_addr_i;
		end else if (rd_next_i) begin
			if (wrap_en_o)
				rd_addr_o[7:0] <= (rd_addr_o[7:0] & ~wrap_mask) | (lo_inc & wrap_mask);
			else
				rd_addr_o <= rd_addr_o + 24'h1;
		end
	end
endmodule // flash_cmd

// ---- dv/flash_cmd_asserts.sv ----
// port assertions for the flash command block
`timescale 1ns/100ps
module flash_cmd_asserts (
	input wire clk_i,
	input wire resetn_i,
	input wire cs_n_i,
	input wire soft_reset_i,
	input wire rd_load_i,
	input wire rd_next_i,
	input wire [23:0] rd_addr_i,
	input wire [23:0] rd_addr_o,
	input wire [3:0] io_oe_o,
	input wire wrap_en_o,
	input wire [1:0] wrap_length_field_o,
	input wire powerdown_o,
	input wire busy_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	wire [23:0] sec = (24'h8 << wrap_length_field_o) - 24'h1;
	wire step = rd_next_i && !rd_load_i;
	property p_rst; $rose(resetn_i) |-> !powerdown_o && !busy_o && !wrap_en_o; endproperty
	property p_soft; soft_reset_i && cs_n_i && $past(cs_n_i, 8) |=> !wrap_en_o; endproperty
	property p_hold; cs_n_i && $past(cs_n_i, 8) && !soft_reset_i |=> $stable(sec); endproperty
	property p_load; rd_load_i |=> rd_addr_o == $past(rd_addr_i); endproperty
	property p_lin; step && !wrap_en_o |=> rd_addr_o == $past(rd_addr_o) + 24'h1; endproperty
	property p_wrap; step && wrap_en_o |=> rd_addr_o ==
		(($past(rd_addr_o) & ~$past(sec)) | (($past(rd_addr_o) + 24'h1) & $past(sec)));
	endproperty
	property p_oe; io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
	property p_busy; $rose(busy_o) |=> busy_o [*8]; endproperty
	property p_pd; $rose(powerdown_o) |-> $past(busy_o); endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	a_soft: assert property (p_soft) else $error("soft reset");
	a_hold: assert property (p_hold) else $error("wrap moved");
	a_load: assert property (p_load) else $error("load");
	a_lin: assert property (p_lin) else $error("linear step");
	a_wrap: assert property (p_wrap) else $error("wrap step");
	a_oe: assert property (p_oe) else $error("lanes");
	a_busy: assert property (p_busy) else $error("busy short");
	a_pd: assert property (p_pd) else $error("entry");
	c_pd: cover property ($rose(powerdown_o));
	c_wrap: cover property (wrap_en_o && rd_next_i);
	c_quad: cover property (io_oe_o == 4'hf);
endmodule // flash_cmd_asserts
bind flash_cmd flash_cmd_asserts i_flash_cmd_asserts (.clk_i, .resetn_i, .cs_n_i, .soft_reset_i,
	.rd_load_i, .rd_next_i, .rd_addr_i, .rd_addr_o, .io_oe_o, .wrap_en_o, .wrap_length_field_o,
	.powerdown_o, .busy_o);

// ---- dv/spi_host.sv ----
// spi host model driving the flash command pins
`timescale 1ns/100ps
module spi_host (
	output logic cs_n_o,
	output logic sclk_o,
	output logic [3:0] io_o,
	input wire [3:0] io_i
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		io_o = 4'h0;
	end
	// one sclk period: lanes set while low, pins taken at the rise
	task automatic clock(input logic [3:0] d, output logic [3:0] q);
		io_o = d;
		#80 sclk_o = 1'b1;
		q = io_i;
		#80 sclk_o = 1'b0;
	endtask
	// msb first on the highest lane; unused lanes toggle every clock
	task automatic send(input logic [31:0] v, input int n, input int w);
		logic [3:0] m;
		logic [3:0] q;
		m = 4'((1 << w) - 1);
		for (int i = n; i > 0; i -= w) begin
			clock((~io_o & ~m) | (4'(v >> (i - w)) & m), q);
		end
	endtask
	task automatic recv(output logic [23:0] v, input int w);
		logic [3:0] q;
		v = 24'h0;
		for (int i = 0; i < 24; i += w) begin
			clock(~io_o, q);
			v = (v << w) | (w == 1 ? q[1] : q & 4'((1 << w) - 1));
		end
	endtask
	task automatic start(input logic [7:0] op);
		cs_n_o = 1'b0;
		#80 send(op, 8, 1);
	endtask
	task automatic stop();
		#80 cs_n_o = 1'b1;
		#200;
	endtask
endmodule // spi_host

// ---- dv/spi_flash_wrap_powerdown_id_tb.sv ----
// self-checking bench for the flash command block
`timescale 1ns/100ps
module spi_flash_wrap_powerdown_id_tb;
	localparam logic [7:0] MAN = 8'h5a; // arbitrary value
	localparam logic [7:0] DEV = 8'h3c; // arbitrary value
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic write_in_progress_flag = 1'b0;
	logic soft_reset_i = 1'b0;
	logic rd_load_i = 1'b0;
	logic rd_next_i = 1'b0;
	logic [23:0] rd_addr_i = 24'h0;
	logic oe_seen = 1'b0;
	logic [23:0] a, v, s;
	logic [7:0] b;
	wire cs_n, sclk, wrap_en, pd, busy;
	wire [3:0] hio, dio, oe;
	wire [3:0] pin = (oe & dio) | (~oe & hio);
	wire [23:0] rd_addr_o;
	wire [1:0] wlen;
	integer fail_count = 0;
	integer samples_checked = 0;
	integer seed = 32'hf558;
	integer m_en = 0;
	integer m_pd = 0;
	flash_cmd #(.MANUF_ID(MAN), .DEVICE_ID(DEV)) i_flash_cmd (.clk_i, .resetn_i, .cs_n_i(cs_n),
		.sclk_i(sclk), .io_i(pin), .io_o(dio), .io_oe_o(oe),
		.write_in_progress_flag_i(write_in_progress_flag),
		.soft_reset_i, .rd_load_i, .rd_next_i, .rd_addr_i, .rd_addr_o, .wrap_en_o(wrap_en),
		.wrap_length_field_o(wlen), .powerdown_o(pd), .busy_o(busy));
	spi_host i_spi_host (.cs_n_o(cs_n), .sclk_o(sclk), .io_o(hio), .io_i(pin));
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) oe_seen <= oe_seen | (oe != 4'h0);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
			fail_count++;
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// new frames only once the recovery span has ended
	task automatic settle();
		for (int k = 0; k < 700 && busy !== 1'b0; k++) @(negedge clk_i);
		chk(busy, 1'b0);
	endtask
	task automatic wrap(input logic [7:0] w);
		v = $random(seed);
		i_spi_host.start(8'h77);
		i_spi_host.send({v[23:0], w}, 32, 4);
		i_spi_host.stop();
		m_en = !w[4];
		s = (24'h8 << w[6:5]) - 24'h1;
		chk({wrap_en, wlen}, {m_en[0], w[6:5]});
	endtask
	task automatic steps();
		@(negedge clk_i);
		rd_addr_i = $random(seed);
		a = rd_addr_i;
		rd_load_i = 1'b1;
		for (int i = 0; i <= 70; i++) begin
			@(negedge clk_i);
			rd_load_i = 1'b0;
			rd_next_i = i < 70;
			chk(rd_addr_o, a);
			a = m_en ? (a & ~s) | ((a + 24'h1) & s) : a + 24'h1;
		end
	endtask
	task automatic idread(input int j, input logic ord);
		logic [7:0] f;
		f = ord ? DEV : MAN;
		v = $random(seed);
		oe_seen = 1'b0;
		i_spi_host.start(8'(8'h90 + 2 * j));
		i_spi_host.send({v[23:1], ord}, 24, 1 << j);
		i_spi_host.send(v, 4 * j * (j + 1), 1 << j);
		i_spi_host.recv(v, 1 << j);
		i_spi_host.stop();
		chk(m_pd ? oe_seen : v, m_pd ? 24'h0 : {f, f ^ MAN ^ DEV, f});
	endtask
	task automatic abread();
		i_spi_host.start(8'hab);
		i_spi_host.send(v, 24, 1);
		i_spi_host.recv(v, 1);
		i_spi_host.stop();
		chk({v, pd}, {DEV, DEV, DEV, 1'b0});
		m_pd = 0;
		settle();
	endtask
	task automatic cmd(input logic [7:0] op, input logic exp);
		i_spi_host.start(op);
		i_spi_host.stop();
		settle();
		chk(pd, exp);
		m_pd = exp;
	endtask
	initial begin
		#400000;
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge clk_i);
		chk({wrap_en, pd, busy}, 3'b000);
		for (int l = 0; l < 8; l++) begin
			b = $random(seed);
			b[6:4] = {l[1:0], l[2]};
			wrap(b);
			steps();
		end
		wrap(8'h00);
		i_spi_host.start(8'h77);
		i_spi_host.send(v, 12, 4);
		i_spi_host.stop();
		chk({wrap_en, wlen}, 3'b100);
		@(negedge clk_i);
		soft_reset_i = 1'b1;
		@(negedge clk_i) soft_reset_i = 1'b0;
		@(negedge clk_i) chk(wrap_en, 1'b0);
		for (int i = 0; i < 6; i++) idread(i % 3, i / 3);
		abread();
		i_spi_host.start(8'hb9);
		i_spi_host.send(v, 1, 1);
		i_spi_host.stop();
		chk({pd, busy}, 2'b00);
		cmd(8'hb9, 1'b1);
		idread(0, 1'b0);
		write_in_progress_flag = 1'b1;
		cmd(8'hab, 1'b1);
		write_in_progress_flag = 1'b0;
		cmd(8'hab, 1'b0);
		cmd(8'hb9, 1'b1);
		abread();
		idread(2, 1'b1);
		report_and_stop();
	end
endmodule // spi_flash_wrap_powerdown_id_tb
